// File: core/sdr_pkg.sv
// package for the serial decimal receiver: constants and carrier types
package sdr_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHAR_NINE = 8'h39;
  localparam logic [3:0] DEC_BASE = 4'hA;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [15:0] TMO_OFF = 16'h0000;
  localparam int unsigned BUF_DEPTH = 2;

  // one received character from the serial receiver
  typedef struct packed {
    logic [7:0] data;
    logic par_err;
  } sdr_char_s;

  // request from local control
  typedef struct packed {
    logic dec_mode;
    logic full_form;
    logic byte_dest;
    logic [15:0] timeout_ms;
  } sdr_req_s;

  // outcome of one receive
  typedef struct packed {
    logic [15:0] value;
    logic timed_out;
    logic par_err;
  } sdr_res_s;
endpackage

// File: core/sdr_receiver.sv
// receive-side formatter: raw byte or ascii decimal parsing with timeout and parity exit
//
// Summary of operation
// - raw mode returns the first received byte as result, with its top bit cleared when parity is enabled.
// - timeout value counts free-running millisecond ticks; the first counted interval may be partial.
// - no character within timeout abandons the receive with a timeout event.
// - parity mismatch in full form abandons the receive with parity event.
// - inline form never reports parity errors.
// - only codes for digits 0 to 9 are numeric.
// - non-numeric characters before the first digit are discarded; waiting continues.
// - each further digit: value times ten plus digit.
// - completion needs a digit followed by a non-numeric character.
// - any non-numeric after digits ends the number and is not added.
// - on the terminator the value is stored and completion signalled.
// - accumulator is 16 bits and wraps modulo 65536.
// - byte destination gets low eight bits; digits accepted despite overflow.
// - frame is 8N1 by default, 7 data bits plus parity when enabled.
module sdr_receiver (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire sdr_pkg::sdr_req_s req,
  input wire logic parity_en,
  input wire logic char_valid,
  input wire sdr_pkg::sdr_char_s char_in,
  output logic char_ready,
  output logic busy,
  output logic res_valid,
  output sdr_pkg::sdr_res_s res,
  input wire logic res_ready
);
  typedef enum {SDR_IDLE, SDR_SEEK, SDR_ACCUM} sdr_state_e;

  function automatic logic sdr_is_digit(input logic [7:0] c);
    sdr_is_digit = (c >= sdr_pkg::CHAR_ZERO) && (c <= sdr_pkg::CHAR_NINE);
  endfunction

  // one base-ten step; the 16-bit result wraps modulo 65536 on purpose
  function automatic logic [15:0] sdr_accum(input logic [15:0] v, input logic [7:0] c);
    sdr_accum = 16'(v * 16'(sdr_pkg::DEC_BASE)) + {8'h00, c - sdr_pkg::CHAR_ZERO};
  endfunction

  // a byte-wide destination keeps only the low eight bits, whatever overflowed
  function automatic logic [15:0] sdr_dest(input logic [15:0] v, input logic byte_dest);
    sdr_dest = byte_dest ? {8'h00, v[7:0]} : v;
  endfunction

  // packs one outcome; every exit of the formatter builds its result here
  function automatic sdr_pkg::sdr_res_s sdr_outcome(input logic [15:0] v, input logic t, input logic p);
    sdr_outcome = '{value: v, timed_out: t, par_err: p};
  endfunction

  // two-entry input buffer so a stall in the formatter loses no character
  sdr_pkg::sdr_char_s buf_mem [sdr_pkg::BUF_DEPTH];
  sdr_pkg::sdr_char_s next_buf0, next_buf1;
  logic [1:0] buf_cnt, next_buf_cnt;
  logic next_char_ready;
  logic buf_rd;
  sdr_pkg::sdr_char_s cur;
  logic cur_valid;

  assign cur = buf_mem[0];
  assign cur_valid = (buf_cnt != 2'h0);

  always_comb begin
    logic wr;
    wr = char_valid && char_ready;
    next_buf0 = buf_mem[0];
    next_buf1 = buf_mem[1];
    next_buf_cnt = buf_cnt;
    if (buf_rd) begin
      next_buf0 = buf_mem[1];
    end
    if (wr) begin
      if (buf_cnt == 2'h0 || (buf_cnt == 2'h1 && buf_rd)) begin
        next_buf0 = char_in;
      end else begin
        next_buf1 = char_in;
      end
    end
    if (wr && !buf_rd) begin
      next_buf_cnt = buf_cnt + 2'h1;
    end else if (!wr && buf_rd) begin
      next_buf_cnt = buf_cnt - 2'h1;
    end
    // offered only when empty: costs throughput, but the sender never races a filling entry
    next_char_ready = (next_buf_cnt == 2'h0);
  end

  // ready is registered from the next count, not from the stored one
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      buf_cnt <= 2'h0;
      char_ready <= 1'b0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else begin
      buf_cnt <= next_buf_cnt;
      char_ready <= next_char_ready;
      buf_mem[0] <= next_buf0;
      buf_mem[1] <= next_buf1;
    end
  end

  // millisecond tick divider, free running
  logic [15:0] div_cnt, next_div_cnt;
  logic ms_tick, next_ms_tick;

  always_comb begin
    next_ms_tick = 1'b0;
    next_div_cnt = div_cnt + 16'h0001;
    if (div_cnt == 16'(sdr_pkg::MS_CYCLES - 1)) begin
      next_div_cnt = 16'h0000;
      next_ms_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
      ms_tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      ms_tick <= next_ms_tick;
    end
  end

  // formatter state: control, accumulator, millisecond count and held outcome
  sdr_state_e state, next_state;
  sdr_pkg::sdr_req_s cfg, next_cfg;
  logic [15:0] acc, next_acc;
  logic [15:0] ms_cnt, next_ms_cnt;
  logic next_busy;
  logic next_res_valid;
  sdr_pkg::sdr_res_s next_res;
  logic [7:0] ch;
  logic ch_perr;
  logic ch_digit;
  logic [15:0] ms_inc;
  logic accept_req;
  logic end_perr;
  logic end_raw;
  logic add_digit;
  logic end_dec;
  logic tmo_step;
  logic end_tmo;
  logic finish;

  // with parity on the top bit carries parity, leaving seven data bits
  always_comb begin
    ch = cur.data;
    if (parity_en) begin
      ch = {1'b0, cur.data[6:0]};
    end
  end

  // the inline form swallows parity errors; only the full form takes the error exit
  assign ch_perr = parity_en && cur.par_err && cfg.full_form;
  assign ch_digit = sdr_is_digit(ch);

  // next count and any exit, shared by control, timeout count and outcome
  assign ms_inc = ms_cnt + 16'h0001;
  assign finish = end_perr || end_raw || end_dec || end_tmo;

  // event decode: what the waiting character or the millisecond tick means this cycle
  always_comb begin
    accept_req = 1'b0;
    buf_rd = 1'b0;
    end_perr = 1'b0;
    end_raw = 1'b0;
    add_digit = 1'b0;
    end_dec = 1'b0;
    tmo_step = 1'b0;
    end_tmo = 1'b0;
    case (state)
      SDR_IDLE: begin
        // a new request waits until the previous outcome is collected
        accept_req = start && !(res_valid && !res_ready);
      end
      SDR_SEEK, SDR_ACCUM: begin
        if (cur_valid) begin
          buf_rd = 1'b1;
          if (ch_perr) begin
            end_perr = 1'b1;
          end else if (!cfg.dec_mode) begin
            end_raw = 1'b1;
          end else if (ch_digit) begin
            add_digit = 1'b1;
          end else if (state == SDR_ACCUM) begin
            end_dec = 1'b1;
          end
          // a non-digit before any digit is dropped and waiting goes on
        end else if (cfg.timeout_ms != sdr_pkg::TMO_OFF && ms_tick) begin
          tmo_step = 1'b1;
          end_tmo = (ms_inc >= cfg.timeout_ms);
        end
      end
      default: begin
        // unreachable codes decode no event
        accept_req = 1'b0;
      end
    endcase
  end

  // control: idle until a request is taken, busy until an outcome is posted
  always_comb begin
    next_state = state;
    next_cfg = cfg;
    next_busy = busy;
    case (state)
      SDR_IDLE: begin
        if (accept_req) begin
          next_cfg = req;
          next_busy = 1'b1;
          next_state = SDR_SEEK;
        end
      end
      SDR_SEEK, SDR_ACCUM: begin
        if (finish) begin
          next_busy = 1'b0;
          next_state = SDR_IDLE;
        end else if (add_digit) begin
          next_state = SDR_ACCUM;
        end
      end
      default: begin
        next_busy = 1'b0;
        next_state = SDR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= SDR_IDLE;
      cfg <= '0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cfg <= next_cfg;
      busy <= next_busy;
    end
  end

  // accumulator: cleared per request, one base-ten step per digit
  always_comb begin
    next_acc = acc;
    if (accept_req) begin
      next_acc = sdr_pkg::VALUE_RST;
    end else if (add_digit) begin
      next_acc = sdr_accum(acc, ch);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc <= sdr_pkg::VALUE_RST;
    end else begin
      acc <= next_acc;
    end
  end

  // timeout count: restarts on each character, steps once per tick while waiting
  always_comb begin
    next_ms_cnt = ms_cnt;
    if (accept_req || buf_rd) begin
      next_ms_cnt = 16'h0000;
    end else if (tmo_step) begin
      next_ms_cnt = ms_inc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ms_cnt <= 16'h0000;
    end else begin
      ms_cnt <= next_ms_cnt;
    end
  end

  // outcome register: posted once, held until the consumer takes it
  always_comb begin
    next_res_valid = res_valid;
    next_res = res;
    if (res_valid && res_ready) begin
      next_res_valid = 1'b0;
    end
    if (end_perr) begin
      next_res = sdr_outcome(acc, 1'b0, 1'b1);
    end else if (end_raw) begin
      next_res = sdr_outcome({8'h00, ch}, 1'b0, 1'b0);
    end else if (end_dec) begin
      next_res = sdr_outcome(sdr_dest(acc, cfg.byte_dest), 1'b0, 1'b0);
    end else if (end_tmo) begin
      next_res = sdr_outcome(acc, 1'b1, 1'b0);
    end
    if (finish) begin
      next_res_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res <= '0;
    end else begin
      res_valid <= next_res_valid;
      res <= next_res;
    end
  end
endmodule

// File: verif/sdr_host.sv
// host terminal model sending characters into the receiver
module sdr_host (
  input wire logic ref_clk,
  output logic char_valid,
  output sdr_pkg::sdr_char_s char_in,
  input wire logic char_ready,
  output logic stuck
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    char_valid = 1'b0;
    char_in = '0;
    stuck = 1'b0;
  end
  // hold until taken, then show the inverse so a stale byte never looks fresh
  task automatic send(input logic [7:0] b, input logic pe, input int gap);
    int i;
    repeat (gap + 1) @(posedge ref_clk);
    char_valid <= 1'b1;
    char_in <= '{data: b, par_err: pe};
    for (i = 0; i < 1000; i++) begin
      @(posedge ref_clk);
      if (char_ready === 1'b1) break;
    end
    if (i == 1000) stuck <= 1'b1;
    char_valid <= 1'b0;
    char_in <= '{data: ~b, par_err: ~pe};
  endtask
endmodule

// File: verif/sdr_receiver_properties.sv
// checker for the receiver's result handshake and outcome fields
module sdr_receiver_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire sdr_pkg::sdr_req_s req,
  input wire logic parity_en,
  input wire logic char_valid,
  input wire sdr_pkg::sdr_char_s char_in,
  input wire logic char_ready,
  input wire logic busy,
  input wire logic res_valid,
  input wire sdr_pkg::sdr_res_s res,
  input wire logic res_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic dm, ff, bd;
  logic [15:0] tmo;
  // keep the accepted request, since req is only valid beside start
  always_ff @(posedge ref_clk) begin
    if (start && !busy && !(res_valid && !res_ready)) begin
      dm <= req.dec_mode;
      ff <= req.full_form;
      bd <= req.byte_dest;
      tmo <= req.timeout_ms;
    end
  end
  sequence s_taken; start && !busy && !(res_valid && !res_ready); endsequence
  sequence s_done; res_valid && !res.timed_out && !res.par_err; endsequence
  property p_take; s_taken |=> busy; endproperty
  property p_hold; res_valid && !res_ready |=> res_valid && $stable(res); endproperty
  property p_cause; $rose(res_valid) |-> $past(busy); endproperty
  property p_excl; res_valid |-> !busy; endproperty
  property p_par; res_valid && res.par_err |-> ff && parity_en && !res.timed_out; endproperty
  property p_tmo; res_valid && res.timed_out |-> tmo != 16'h0000; endproperty
  property p_byte; s_done |-> !bd || res.value[15:8] == 8'h00; endproperty
  property p_raw; s_done |-> dm || res.value[15:8] == 8'h00; endproperty
  a_take: assert property (p_take) else $error("start not taken");
  a_hold: assert property (p_hold) else $error("result moved");
  a_cause: assert property (p_cause) else $error("result while idle");
  a_excl: assert property (p_excl) else $error("busy with result");
  a_par: assert property (p_par) else $error("parity exit");
  a_tmo: assert property (p_tmo) else $error("timeout while off");
  a_byte: assert property (p_byte) else $error("byte result wide");
  a_raw: assert property (p_raw) else $error("raw result wide");
endmodule
bind sdr_receiver sdr_receiver_properties chk (.ref_clk(ref_clk), .rst_n(rst_n), .start(start), .req(req),
  .parity_en(parity_en), .char_valid(char_valid), .char_in(char_in), .char_ready(char_ready), .busy(busy),
  .res_valid(res_valid), .res(res), .res_ready(res_ready));

// File: verif/sdr_receiver_test.sv
// self-checking bench for the serial decimal receiver
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module sdr_receiver_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, start = 1'b0, parity_en = 1'b0, res_ready = 1'b0;
  logic char_valid, char_ready, busy, res_valid, stuck;
  sdr_pkg::sdr_req_s req = '0;
  sdr_pkg::sdr_char_s char_in;
  sdr_pkg::sdr_res_s res;
  int fail_count = 0, n_compared = 0;
  sdr_receiver uut (.ref_clk(ref_clk), .rst_n(rst_n), .start(start), .req(req), .parity_en(parity_en),
    .char_valid(char_valid), .char_in(char_in), .char_ready(char_ready), .busy(busy),
    .res_valid(res_valid), .res(res), .res_ready(res_ready));
  sdr_host host (.ref_clk(ref_clk), .char_valid(char_valid), .char_in(char_in), .char_ready(char_ready),
    .stuck(stuck));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic results();
    if (stuck !== 1'b0) fail_count++;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic begin_rx(input logic dm, input logic ff, input logic bd, input logic [15:0] tmo);
    @(posedge ref_clk);
    start <= 1'b1;
    req <= '{dec_mode: dm, full_form: ff, byte_dest: bd, timeout_ms: tmo};
    @(posedge ref_clk);
    start <= 1'b0;
  endtask
  // alternate prompt and slow characters
  task automatic send_str(input string s);
    int i;
    for (i = 0; i < s.len(); i++) host.send(s[i], 1'b0, i % 2);
  endtask
  // collect one outcome; the result is held a few cycles before it is accepted
  task automatic expect_res(input string nm, input logic [15:0] v, input logic t, input logic p);
    int i;
    for (i = 0; i < 60000; i++) begin
      @(posedge ref_clk);
      if (res_valid === 1'b1) break;
    end
    if (i == 60000) begin
      fail_count++;
      results();
    end
    repeat (2) @(posedge ref_clk);
    `CHK("value", v, res.value)
    `CHK("timed_out", t, res.timed_out)
    `CHK("par_err", p, res.par_err)
    `CHK("busy", 1'b0, busy)
    res_ready <= 1'b1;
    @(posedge ref_clk);
    res_ready <= 1'b0;
    $display("test %s done", nm);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    begin_rx(1'b0, 1'b1, 1'b0, 16'h0000);
    send_str("A");
    expect_res("raw", 16'h0041, 1'b0, 1'b0);
    begin_rx(1'b1, 1'b1, 1'b0, 16'h0000);
    send_str("/:Z9012");
    repeat (6) @(posedge ref_clk);
    `CHK("waiting", 1'b0, res_valid)
    `CHK("busy", 1'b1, busy)
    `CHK("ready", 1'b1, char_ready)
    send_str(":");
    expect_res("dec", 16'h2334, 1'b0, 1'b0);
    begin_rx(1'b1, 1'b1, 1'b0, 16'h0000);
    send_str("70000 ");
    expect_res("wrap", 16'h1170, 1'b0, 1'b0);
    begin_rx(1'b1, 1'b1, 1'b1, 16'h0000);
    send_str("300 ");
    expect_res("byte", 16'h002C, 1'b0, 1'b0);
    begin_rx(1'b0, 1'b1, 1'b0, 16'h0001);
    expect_res("timeout", 16'h0000, 1'b1, 1'b0);
    parity_en <= 1'b1;
    begin_rx(1'b1, 1'b1, 1'b0, 16'h0000);
    host.send(8'h37, 1'b1, 0);
    expect_res("parity", 16'h0000, 1'b0, 1'b1);
    begin_rx(1'b1, 1'b0, 1'b0, 16'h0000);
    host.send(8'h37, 1'b1, 0);
    send_str(" ");
    expect_res("inline", 16'h0007, 1'b0, 1'b0);
    results();
  end
endmodule
